// ===== src/bcb_top.sv
// channel b break condition comparator with apb register file and interrupt
// Contract
// RQ1 - hold 32-bit break address, compare bus address
// RQ2 - address mask one excludes that bit
// RQ3 - 32-bit readable writable break data operand
// RQ4 - data mask one excludes that bit
// RQ5 - software sets size when data compared
// RQ6 - byte data lane follows address parity
// RQ7 - master select: 00 off, x1 cpu, 10 dma
// RQ8 - access select: off, fetch, data, either
// RQ9 - direction select: off, read, write, either
// RQ10 - size select: none, byte, word, longword
// RQ11 - qualifier bits 15 to 8 read zero
// RQ12 - qualifier 16-bit, resets to zero, compare off
// RQ13 - match needs all conditions same cycle
// RQ14 - sticky cpu and dma flags, write zero clears
// RQ15 - space id mask one excludes space id
`timescale 1ns/1ns
module bcb_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// monitored bus cycle
	input  wire logic        bus_valid,
	input  wire logic        bus_is_dma,
	input  wire logic        bus_is_fetch,
	input  wire logic        bus_write,
	input  wire logic [1:0]  bus_size,
	input  wire logic [31:0] bus_address,
	input  wire logic [31:0] bus_data,
	input  wire logic        space_id_hit,
	// results
	output logic             cpu_match,
	output logic             dma_match,
	output logic             irq
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] chb_break_address;	// break address
	logic [31:0] chb_address_mask;	// address mask
	logic [31:0] chb_break_data;	// break data
	logic [31:0] chb_data_mask;	// data mask
	logic [15:0] chb_cycle_qualifier;	// cycle qualifier
	logic        data_en;	// data bus in condition
	logic        chb_space_id_mask;	// exclude space id
	logic        chb_cpu_match_flag;	// sticky cpu flag
	logic        chb_dma_match_flag;	// sticky dma flag
	logic [1:0]  int_status;	// sticky event bits
	logic [1:0]  int_mask;	// interrupt enable bits
	logic [31:0] next_prdata;	// read mux
	logic        addr_hit;	// address is mapped
	logic        wr_en;	// access phase write
	logic        rd_en;	// setup phase read
	logic [31:0] wmask;	// byte lane mask from pstrb
	logic [31:0] qual_merged;	// qualifier word after lane merge

	bcb_match_if mif ();	// settings to matcher

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// byte lanes to bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// merge write data into a word under the lane mask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] msk);
		merge = (old & ~msk) | (wd & msk);
	endfunction

	assign addr_hit = (paddr == bcb_pkg::OFF_BREAK_ADDRESS) || (paddr == bcb_pkg::OFF_ADDRESS_MASK) ||
		(paddr == bcb_pkg::OFF_BREAK_DATA) || (paddr == bcb_pkg::OFF_DATA_MASK) ||
		(paddr == bcb_pkg::OFF_CYCLE_QUAL) || (paddr == bcb_pkg::OFF_CONTROL) ||
		(paddr == bcb_pkg::OFF_INT_STATUS) || (paddr == bcb_pkg::OFF_INT_MASK);
	// write lands once, at the edge that ends the answering access cycle
	assign wr_en = psel && penable && pready && pwrite && addr_hit;
	assign rd_en = psel && !penable && !pwrite;
	assign wmask = lane_mask(pstrb);
	// qualifier merged on a full word so lanes line up with pwdata
	assign qual_merged = merge({16'h0000, chb_cycle_qualifier}, pwdata, wmask);

	// ----------------------------------------------------------------
	// comparison registers
	// ----------------------------------------------------------------
	// address and data operand writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chb_break_address <= bcb_pkg::RST_WORD;
			chb_address_mask  <= bcb_pkg::RST_WORD;
			chb_break_data    <= bcb_pkg::RST_WORD;
			chb_data_mask     <= bcb_pkg::RST_WORD;
		end else if (wr_en) begin
			// RQ1 RQ2 RQ3 RQ4 operand register writes
			case (paddr)
				bcb_pkg::OFF_BREAK_ADDRESS: chb_break_address <= merge(chb_break_address, pwdata, wmask);
				bcb_pkg::OFF_ADDRESS_MASK:  chb_address_mask  <= merge(chb_address_mask, pwdata, wmask);
				bcb_pkg::OFF_BREAK_DATA:    chb_break_data    <= merge(chb_break_data, pwdata, wmask);
				bcb_pkg::OFF_DATA_MASK:     chb_data_mask     <= merge(chb_data_mask, pwdata, wmask);
				default:                    chb_break_data    <= chb_break_data;
			endcase
		end
	end

	// qualifier write, only bits 7 to 0 exist
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RQ12 qualifier resets to zero
			chb_cycle_qualifier <= bcb_pkg::RST_QUAL;
		end else if (wr_en && paddr == bcb_pkg::OFF_CYCLE_QUAL) begin
			// RQ11 reserved bits held at zero
			chb_cycle_qualifier <= {8'h00, qual_merged[bcb_pkg::QUAL_USED_HI:0]};
		end
	end

	// control bits other than flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_en           <= 1'b0;
			chb_space_id_mask <= 1'b0;
		end else if (wr_en && paddr == bcb_pkg::OFF_CONTROL) begin
			if (pstrb[0]) begin
				data_en <= pwdata[bcb_pkg::CTL_DATA_EN];
			end
			// RQ15 space id mask control
			if (pstrb[2]) begin
				chb_space_id_mask <= pwdata[bcb_pkg::CTL_SPACE_ID_MASK];
			end
		end
	end

	// ----------------------------------------------------------------
	// matcher
	// ----------------------------------------------------------------
	assign mif.break_address = chb_break_address;
	assign mif.address_mask  = chb_address_mask;
	assign mif.break_data    = chb_break_data;
	assign mif.data_mask     = chb_data_mask;
	assign mif.qualifier     = chb_cycle_qualifier;
	assign mif.data_en       = data_en;
	assign mif.space_id_mask = chb_space_id_mask;
	assign mif.space_id_hit  = space_id_hit;

	// combinational compare of the current bus cycle
	bcb_matcher u_matcher (
		.m            (mif.cmp),
		.bus_valid    (bus_valid),
		.bus_is_dma   (bus_is_dma),
		.bus_is_fetch (bus_is_fetch),
		.bus_write    (bus_write),
		.bus_size     (bus_size),
		.bus_address  (bus_address),
		.bus_data     (bus_data)
	);

	// registered match pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_match <= 1'b0;
			dma_match <= 1'b0;
		end else begin
			// RQ13 one cycle pulse per matching bus cycle
			cpu_match <= mif.cpu_hit;
			dma_match <= mif.dma_hit;
		end
	end

	// ----------------------------------------------------------------
	// sticky flags and interrupt
	// ----------------------------------------------------------------
	// match flags, set wins over a zero write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chb_cpu_match_flag <= 1'b0;
			chb_dma_match_flag <= 1'b0;
		end else begin
			// RQ14 set by hit, cleared by writing zero
			if (mif.cpu_hit) begin
				chb_cpu_match_flag <= 1'b1;
			end else if (wr_en && paddr == bcb_pkg::OFF_CONTROL && pstrb[1] &&
				!pwdata[bcb_pkg::CTL_CPU_FLAG]) begin
				chb_cpu_match_flag <= 1'b0;
			end
			if (mif.dma_hit) begin
				chb_dma_match_flag <= 1'b1;
			end else if (wr_en && paddr == bcb_pkg::OFF_CONTROL && pstrb[1] &&
				!pwdata[bcb_pkg::CTL_DMA_FLAG]) begin
				chb_dma_match_flag <= 1'b0;
			end
		end
	end

	// interrupt status, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= bcb_pkg::RST_PAIR;
		end else begin
			int_status <= (int_status &
				~((wr_en && paddr == bcb_pkg::OFF_INT_STATUS && pstrb[0]) ? pwdata[1:0] : 2'h0))
				| {mif.dma_hit, mif.cpu_hit};
		end
	end

	// interrupt mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= bcb_pkg::RST_PAIR;
		end else if (wr_en && paddr == bcb_pkg::OFF_INT_MASK && pstrb[0]) begin
			int_mask <= pwdata[1:0];
		end
	end

	// level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// read mux, unmapped reads zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			bcb_pkg::OFF_BREAK_ADDRESS: next_prdata = chb_break_address;
			bcb_pkg::OFF_ADDRESS_MASK:  next_prdata = chb_address_mask;
			bcb_pkg::OFF_BREAK_DATA:    next_prdata = chb_break_data;
			bcb_pkg::OFF_DATA_MASK:     next_prdata = chb_data_mask;
			// RQ11 upper half and reserved read zero
			bcb_pkg::OFF_CYCLE_QUAL:    next_prdata = {16'h0000, chb_cycle_qualifier};
			bcb_pkg::OFF_CONTROL: begin
				next_prdata[bcb_pkg::CTL_SPACE_ID_MASK] = chb_space_id_mask;
				next_prdata[bcb_pkg::CTL_CPU_FLAG]      = chb_cpu_match_flag;
				next_prdata[bcb_pkg::CTL_DMA_FLAG]      = chb_dma_match_flag;
				next_prdata[bcb_pkg::CTL_DATA_EN]       = data_en;
			end
			bcb_pkg::OFF_INT_STATUS:    next_prdata = {30'h0000_0000, int_status};
			bcb_pkg::OFF_INT_MASK:      next_prdata = {30'h0000_0000, int_mask};
			default:                    next_prdata = 32'h0000_0000;
		endcase
	end

	// read data captured in setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= next_prdata;
		end
	end

	// ready and error: one wait state, answer in second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_hit;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// a zero write to a flag must not clear a simultaneous hit
	sequence s_cpu_hit;
		mif.cpu_hit;
	endsequence

	a_cpu_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		s_cpu_hit |=> chb_cpu_match_flag)
		else $error("cpu flag not set after hit");
	a_dma_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		mif.dma_hit |=> chb_dma_match_flag)
		else $error("dma flag not set after hit");
	a_flag_hold_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		$fell(chb_cpu_match_flag) |-> $past(wr_en) && $past(paddr) == bcb_pkg::OFF_CONTROL)
		else $error("cpu flag fell without write");
	a_qual_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		chb_cycle_qualifier[15:8] == 8'h00)
		else $error("reserved qualifier bits set");
	a_master_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		chb_cycle_qualifier[7:6] == 2'h0 |-> !mif.cpu_hit && !mif.dma_hit)
		else $error("hit with master select off");
	a_dma_needs_dma: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		mif.dma_hit |-> bus_is_dma && chb_cycle_qualifier[7:6] == 2'h2)
		else $error("dma hit without dma cycle");
	a_addr_masked_eq: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		mif.cpu_hit |-> ((bus_address ^ chb_break_address) & ~chb_address_mask) == 32'h0)
		else $error("hit with unmasked address mismatch");
	a_data_masked_eq: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		(mif.cpu_hit && data_en) |-> ((bus_data ^ chb_break_data) & ~chb_data_mask) == 32'h0)
		else $error("hit with unmasked data mismatch");
	a_dir_read_only: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
		(mif.cpu_hit && chb_cycle_qualifier[3:2] == 2'h1) |-> !bus_write)
		else $error("read only hit on write");
	a_size_checked: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
		(mif.cpu_hit && chb_cycle_qualifier[1:0] != 2'h0) |-> bus_size == chb_cycle_qualifier[1:0])
		else $error("hit with wrong size");
	a_match_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
		mif.cpu_hit |=> cpu_match && chb_cpu_match_flag)
		else $error("match pulse missing");
	a_ready_one_wait: assert property (@(posedge pclk) disable iff (!presetn) // apb wait state
		(psel && penable && !pready) |=> pready)
		else $error("pready late");
endmodule

// ===== src/bcb_pkg.sv
// package of offsets, field positions and encodings for the channel b break comparator
package bcb_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_BREAK_ADDRESS = 8'h00;	// chb_break_address
	localparam logic [7:0] OFF_ADDRESS_MASK  = 8'h04;	// chb_address_mask
	localparam logic [7:0] OFF_BREAK_DATA    = 8'h08;	// chb_break_data
	localparam logic [7:0] OFF_DATA_MASK     = 8'h0C;	// chb_data_mask
	localparam logic [7:0] OFF_CYCLE_QUAL    = 8'h10;	// chb_cycle_qualifier
	localparam logic [7:0] OFF_CONTROL       = 8'h14;	// data enable, space id mask, flags
	localparam logic [7:0] OFF_INT_STATUS    = 8'h18;	// sticky event status
	localparam logic [7:0] OFF_INT_MASK      = 8'h1C;	// interrupt mask

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;	// every register resets to zero
	localparam logic [15:0] RST_QUAL = 16'h0000;	// qualifier reset
	localparam logic [1:0]  RST_PAIR = 2'h0;	// two-bit status or mask reset

	// ----------------------------------------------------------------
	// qualifier field positions
	// ----------------------------------------------------------------
	localparam int QUAL_MASTER_HI = 7;	// chb_master_sel_hi
	localparam int QUAL_MASTER_LO = 6;	// chb_master_sel_lo
	localparam int QUAL_ACCESS_HI = 5;	// chb_access_type_hi
	localparam int QUAL_ACCESS_LO = 4;	// chb_access_type_lo
	localparam int QUAL_DIR_HI    = 3;	// chb_direction_hi
	localparam int QUAL_DIR_LO    = 2;	// chb_direction_lo
	localparam int QUAL_SIZE_HI   = 1;	// chb_size_sel_hi
	localparam int QUAL_SIZE_LO   = 0;	// chb_size_sel_lo
	localparam int QUAL_USED_HI   = 7;	// top implemented bit

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int CTL_SPACE_ID_MASK = 20;	// chb_space_id_mask
	localparam int CTL_CPU_FLAG      = 14;	// chb_cpu_match_flag
	localparam int CTL_DMA_FLAG      = 12;	// chb_dma_match_flag
	localparam int CTL_DATA_EN       = 3;	// include data bus in condition

	// ----------------------------------------------------------------
	// status and mask bits
	// ----------------------------------------------------------------
	localparam int INT_CPU = 0;	// cpu match event
	localparam int INT_DMA = 1;	// dma match event

	// ----------------------------------------------------------------
	// operand size encodings on the monitored bus
	// ----------------------------------------------------------------
	localparam logic [1:0] SIZE_NONE = 2'h0;	// size not checked
	localparam logic [1:0] SIZE_BYTE = 2'h1;	// byte
	localparam logic [1:0] SIZE_WORD = 2'h2;	// word
	localparam logic [1:0] SIZE_LONG = 2'h3;	// longword

endpackage

// ===== src/bcb_match_if.sv
// interface carrying comparator settings and result between top and matcher
`timescale 1ns/1ns
interface bcb_match_if;
	logic [31:0] break_address;	// address operand
	logic [31:0] address_mask;	// address mask, one excludes bit
	logic [31:0] break_data;	// data operand
	logic [31:0] data_mask;	// data mask, one excludes bit
	logic [15:0] qualifier;	// cycle qualifier
	logic        data_en;	// include data bus
	logic        space_id_mask;	// exclude space id
	logic        space_id_hit;	// space id agrees
	logic        cpu_hit;	// cpu condition met this cycle
	logic        dma_hit;	// dma condition met this cycle

	modport cfg (
		output break_address, address_mask, break_data, data_mask,
		output qualifier, data_en, space_id_mask, space_id_hit,
		input  cpu_hit, dma_hit
	);
	modport cmp (
		input  break_address, address_mask, break_data, data_mask,
		input  qualifier, data_en, space_id_mask, space_id_hit,
		output cpu_hit, dma_hit
	);
endinterface

// ===== src/bcb_matcher.sv
// combinational matcher comparing one bus cycle to the channel b settings
`timescale 1ns/1ns
module bcb_matcher (
	// settings and result
	bcb_match_if.cmp             m,
	// monitored bus cycle
	input  wire logic            bus_valid,
	input  wire logic            bus_is_dma,
	input  wire logic            bus_is_fetch,
	input  wire logic            bus_write,
	input  wire logic [1:0]      bus_size,
	input  wire logic [31:0]     bus_address,
	input  wire logic [31:0]     bus_data
);
	logic [1:0] master_sel;	// master selector pair
	logic [1:0] access_sel;	// access type pair
	logic [1:0] dir_sel;	// direction pair
	logic [1:0] size_sel;	// size pair
	logic       addr_ok;	// unmasked address bits agree
	logic       data_ok;	// unmasked data bits agree
	logic       qual_ok;	// access, direction and size agree
	logic       any_ok;	// all but master agree

	assign master_sel = {m.qualifier[bcb_pkg::QUAL_MASTER_HI], m.qualifier[bcb_pkg::QUAL_MASTER_LO]};
	assign access_sel = {m.qualifier[bcb_pkg::QUAL_ACCESS_HI], m.qualifier[bcb_pkg::QUAL_ACCESS_LO]};
	assign dir_sel    = {m.qualifier[bcb_pkg::QUAL_DIR_HI], m.qualifier[bcb_pkg::QUAL_DIR_LO]};
	assign size_sel   = {m.qualifier[bcb_pkg::QUAL_SIZE_HI], m.qualifier[bcb_pkg::QUAL_SIZE_LO]};

	// masked compare, a mask bit of one removes that bit
	function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] msk);
		masked_eq = ((a ^ b) & ~msk) == 32'h0000_0000;
	endfunction

	// RQ1 RQ2 address masked compare
	assign addr_ok = masked_eq(bus_address, m.break_address, m.address_mask);

	// RQ3 RQ4 RQ6 data compare, byte lane is software placed
	assign data_ok = !m.data_en || masked_eq(bus_data, m.break_data, m.data_mask);

	// qualifier decode for access, direction and size
	always_comb begin
		qual_ok = 1'b1;
		// RQ8 access type select
		case (access_sel)
			2'h1:    qual_ok = qual_ok && bus_is_fetch;
			2'h2:    qual_ok = qual_ok && !bus_is_fetch;
			2'h3:    qual_ok = qual_ok;
			default: qual_ok = 1'b0;
		endcase
		// RQ9 direction select
		case (dir_sel)
			2'h1:    qual_ok = qual_ok && !bus_write;
			2'h2:    qual_ok = qual_ok && bus_write;
			2'h3:    qual_ok = qual_ok;
			default: qual_ok = 1'b0;
		endcase
		// RQ10 operand size select
		case (size_sel)
			bcb_pkg::SIZE_NONE: qual_ok = qual_ok;
			default:            qual_ok = qual_ok && (bus_size == size_sel);
		endcase
	end

	// RQ15 space id only counts when not masked
	// RQ13 all conditions in one cycle
	assign any_ok = bus_valid && addr_ok && data_ok && qual_ok &&
		(m.space_id_mask || m.space_id_hit);

	// RQ7 master select, x1 cpu, 10 dma, 00 off
	assign m.cpu_hit = any_ok && master_sel[0] && !bus_is_dma;
	assign m.dma_hit = any_ok && (master_sel == 2'h2) && bus_is_dma;
endmodule

// ===== bench/bcb_bus_model.sv
// behavioural model of the core and dma buses presenting monitored cycles
`timescale 1ns/1ns
module bcb_bus_model (
	// clock
	input  wire logic        pclk,
	// monitored bus cycle
	output logic             bus_valid,
	output logic             bus_is_dma,
	output logic             bus_is_fetch,
	output logic             bus_write,
	output logic [1:0]       bus_size,
	output logic [31:0]      bus_address,
	output logic [31:0]      bus_data,
	output logic             space_id_hit
);
	// idle bus at time zero
	initial begin
		{bus_valid, bus_is_dma, bus_is_fetch, bus_write, bus_size, space_id_hit} = 6'h00;
		bus_address = 32'h0000_0000;
		bus_data = 32'h0000_0000;
	end

	// one bus cycle for one edge, then lines released
	task automatic cycle(input logic dma, fetch, wr, input logic [1:0] sz,
		input logic [31:0] a, d, input logic hit);
		@(posedge pclk);
		bus_valid <= 1'b1;
		{bus_is_dma, bus_is_fetch, bus_write, bus_size} <= {dma, fetch, wr, sz};
		{bus_address, bus_data, space_id_hit} <= {a, d, hit};
		@(posedge pclk);
		// released dma, address, data and space id lines show inverted values so stale data never matches
		bus_valid <= 1'b0;
		{bus_is_dma, bus_address, bus_data, space_id_hit} <= {~dma, ~a, ~d, ~hit};
	endtask
endmodule

// ===== bench/bcb_top_tb.sv
// self-checking testbench of the channel b break comparator
`timescale 1ns/1ns
module bcb_top_tb;
	// ------------------------------------------------------------
	// signals and constants
	// ------------------------------------------------------------
	logic        pclk = 1'b0;	// 250 mhz clock
	logic        presetn = 1'b0;	// reset, active low
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;	// whole words only
	logic [31:0] prdata;
	logic        pready, pslverr, cpu_match, dma_match, irq;
	logic        bus_valid, bus_is_dma, bus_is_fetch, bus_write, space_id_hit;
	logic [1:0]  bus_size;
	logic [31:0] bus_address, bus_data;
	int          n_mismatch = 0;
	int          n_checks = 0;
	localparam logic [7:0]  QUAL = bcb_pkg::OFF_CYCLE_QUAL;
	localparam logic [7:0]  CTRL = bcb_pkg::OFF_CONTROL;
	localparam logic [7:0]  STAT = bcb_pkg::OFF_INT_STATUS;
	localparam logic [31:0] BA = 32'h1234_5678;	// even break address
	localparam logic [31:0] SPM = 32'h0010_0000;	// space id excluded

	always #2 pclk = ~pclk;

	bcb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .bus_valid, .bus_is_dma, .bus_is_fetch, .bus_write,
		.bus_size, .bus_address, .bus_data, .space_id_hit, .cpu_match, .dma_match, .irq);
	bcb_bus_model bus (.pclk, .bus_valid, .bus_is_dma, .bus_is_fetch, .bus_write,
		.bus_size, .bus_address, .bus_data, .space_id_hit);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		chk({31'h0, pready}, 32'h1, "apb answer missing");
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, msg);
	endtask
	// one monitored cycle, match pulses judged in the following cycle
	task automatic cyc(input logic dma, fetch, w, input logic [1:0] sz,
		input logic [31:0] a, d, input logic hit, input logic [1:0] exp, input string msg);
		bus.cycle(dma, fetch, w, sz, a, d, hit);
		@(posedge pclk);
		chk({30'h0, dma_match, cpu_match}, {30'h0, exp}, msg);
	endtask
	task automatic cpu(input logic [1:0] exp, input string msg);
		cyc(1'b0, 1'b0, 1'b0, bcb_pkg::SIZE_LONG, BA, 32'h0, 1'b1, exp, msg);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0, "reset value");
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk(r, 32'h0, "unmapped read data");
		chk({31'h0, e}, 32'h1, "unmapped read error");
		chk({31'h0, irq}, 32'h0, "irq after reset");
	endtask
	task automatic t_regs;
		wr(bcb_pkg::OFF_BREAK_ADDRESS, 32'hA5C3_0FF1);
		rd(bcb_pkg::OFF_BREAK_ADDRESS, 32'hA5C3_0FF1, "address rw");
		wr(bcb_pkg::OFF_ADDRESS_MASK, 32'h5A3C_F00E);
		rd(bcb_pkg::OFF_ADDRESS_MASK, 32'h5A3C_F00E, "address mask rw");
		wr(bcb_pkg::OFF_BREAK_DATA, 32'hDEAD_BEEF);
		rd(bcb_pkg::OFF_BREAK_DATA, 32'hDEAD_BEEF, "data rw");
		wr(bcb_pkg::OFF_DATA_MASK, 32'h0F0F_1234);
		rd(bcb_pkg::OFF_DATA_MASK, 32'h0F0F_1234, "data mask rw");
		wr(QUAL, 32'hFFFF_FFFF);
		rd(QUAL, 32'h0000_00FF, "reserved bits");
		wr(bcb_pkg::OFF_ADDRESS_MASK, 32'h0);
		wr(bcb_pkg::OFF_BREAK_ADDRESS, BA);
		wr(CTRL, SPM);
	endtask
	task automatic t_fields;
		for (int m = 0; m < 4; m++) begin
			wr(QUAL, {24'h0, 2'(m), 6'b111100});
			cpu({1'b0, m[0]}, "cpu master");
			cyc(1'b1, 1'b0, 1'b0, 2'h3, BA, 32'h0, 1'b1, {m == 2, 1'b0}, "dma master");
			wr(QUAL, {24'h0, 2'b01, 2'(m), 4'b1100});
			cyc(1'b0, 1'b1, 1'b0, 2'h3, BA, 32'h0, 1'b1, {1'b0, m[0]}, "fetch");
			cyc(1'b0, 1'b0, 1'b0, 2'h3, BA, 32'h0, 1'b1, {1'b0, m[1]}, "data access");
			wr(QUAL, {24'h0, 4'b0111, 2'(m), 2'b00});
			cyc(1'b0, 1'b0, 1'b0, 2'h3, BA, 32'h0, 1'b1, {1'b0, m[0]}, "read");
			cyc(1'b0, 1'b0, 1'b1, 2'h3, BA, 32'h0, 1'b1, {1'b0, m[1]}, "write");
			wr(QUAL, {24'h0, 6'b011111, 2'(m)});
			for (int b = 1; b < 4; b++)
				cyc(1'b0, 1'b0, 1'b0, 2'(b), BA, 32'h0, 1'b1, {1'b0, m == 0 || m == b}, "size");
		end
	endtask
	task automatic t_match;
		wr(QUAL, 32'h7C);
		wr(bcb_pkg::OFF_ADDRESS_MASK, 32'h0000_00FF);
		cyc(1'b0, 1'b0, 1'b0, 2'h3, 32'h1234_56AB, 32'h0, 1'b1, 2'b01, "masked bits");
		cyc(1'b0, 1'b0, 1'b0, 2'h3, 32'h1234_57AB, 32'h0, 1'b1, 2'b00, "kept bit");
		wr(bcb_pkg::OFF_ADDRESS_MASK, 32'h0);
		cyc(1'b0, 1'b0, 1'b0, 2'h3, 32'h1234_5679, 32'h0, 1'b1, 2'b00, "address lsb");
		wr(CTRL, SPM | 32'h8);
		wr(bcb_pkg::OFF_BREAK_DATA, 32'h0000_AB00);
		wr(bcb_pkg::OFF_DATA_MASK, 32'hFFFF_00FF);
		wr(QUAL, 32'h7D);
		cyc(1'b0, 1'b0, 1'b0, 2'h1, BA, 32'h1111_AB22, 1'b1, 2'b01, "byte lane");
		cyc(1'b0, 1'b0, 1'b0, 2'h1, BA, 32'h0000_00AB, 1'b1, 2'b00, "wrong lane");
		cyc(1'b0, 1'b0, 1'b0, 2'h2, BA, 32'h0000_AB00, 1'b1, 2'b00, "size differs");
		wr(CTRL, 32'h0);
		wr(QUAL, 32'h7C);
		cpu(2'b01, "space id hit");
		cyc(1'b0, 1'b0, 1'b0, 2'h3, BA, 32'h0, 1'b0, 2'b00, "space id miss");
	endtask
	task automatic t_flags;
		wr(CTRL, SPM);
		wr(STAT, 32'h3);
		wr(bcb_pkg::OFF_INT_MASK, 32'h1);
		rd(STAT, 32'h0, "status cleared");
		cpu(2'b01, "cpu hit");
		rd(CTRL, 32'h0010_4000, "cpu flag set");
		rd(STAT, 32'h1, "cpu status");
		chk({31'h0, irq}, 32'h1, "irq raised");
		wr(CTRL, 32'h0010_5000);
		rd(CTRL, 32'h0010_4000, "flag write one");
		wr(QUAL, 32'hBC);
		cyc(1'b1, 1'b0, 1'b0, 2'h3, BA, 32'h0, 1'b0, 2'b10, "dma hit");
		rd(CTRL, 32'h0010_5000, "dma flag set");
		wr(STAT, 32'h1);
		rd(STAT, 32'h2, "status write one clear");
		chk({31'h0, irq}, 32'h0, "dma event masked");
		wr(CTRL, SPM);
		rd(CTRL, SPM, "flags write zero");
	endtask

	// ------------------------------------------------------------
	// sequence, verdict and watchdog
	// ------------------------------------------------------------
	task automatic test_done;
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_regs;
		t_fields;
		t_match;
		t_flags;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done;
	end
endmodule
